// ==== rrmeb_pkg.sv ====
// package of constants and helpers for the receive rate-match elastic buffer
package rrmeb_pkg;
   localparam int          RRMEB_DATA_W     = 64;
   localparam int          RRMEB_CTRL_W     = 8;
   localparam int          RRMEB_WORD_W     = RRMEB_DATA_W + RRMEB_CTRL_W;
   localparam int          RRMEB_DEPTH      = 32;
   localparam int          RRMEB_AW         = 5;
   localparam int          RRMEB_LVL_W      = RRMEB_AW + 1;
   localparam logic [5:0]  RRMEB_HALF       = 6'h10;
   localparam logic [6:0]  RRMEB_CC_LIMIT   = 7'h40;
   localparam logic [7:0]  RRMEB_CH_IDLE    = 8'h07;
   localparam logic [7:0]  RRMEB_CH_START   = 8'hFB;
   localparam logic [7:0]  RRMEB_CH_TERM    = 8'hFD;
   localparam logic [63:0] RRMEB_IDLE_D     = 64'h0707070707070707;
   localparam logic [7:0]  RRMEB_IDLE_C     = 8'hFF;
   localparam logic [63:0] RRMEB_LFAULT_D   = 64'h0100009C0100009C;
   localparam logic [7:0]  RRMEB_LFAULT_C   = 8'h11;
   localparam logic [63:0] RRMEB_RST_D      = RRMEB_LFAULT_D;
   localparam logic [7:0]  RRMEB_RST_C      = RRMEB_LFAULT_C;

   // whole word of idle characters, the rate-match sequence
   function automatic logic rrmeb_is_rms(input logic [63:0] d, input logic [7:0] c);
      logic ok;
      ok = (c == RRMEB_IDLE_C);
      for (int i = 0; i < 8; i++) begin
         ok = ok & (d[8*i +: 8] == RRMEB_CH_IDLE);
      end
      return ok;
   endfunction

   // start character in lane 0 or lane 4
   function automatic logic rrmeb_has_start(input logic [63:0] d, input logic [7:0] c);
      return (c[0] && d[7:0] == RRMEB_CH_START) || (c[4] && d[39:32] == RRMEB_CH_START);
   endfunction

   // terminate character in any lane
   function automatic logic rrmeb_has_term(input logic [63:0] d, input logic [7:0] c);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         hit = hit | (c[i] && d[8*i +: 8] == RRMEB_CH_TERM);
      end
      return hit;
   endfunction
endpackage

// ==== rrmeb_fifo.sv ====
// synchronous fifo with valid/ready on both sides and a fill level
`timescale 1ns/100ps
module rrmeb_fifo #(
   parameter int WIDTH = 72,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_valid,
   input  wire logic [WIDTH-1:0] wr_data,
   output      logic             wr_ready,
   output      logic             rd_valid,
   output      logic [WIDTH-1:0] rd_data,
   input  wire logic             rd_ready,
   output      logic [AW:0]      level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_q;
   logic [AW-1:0]    rptr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   ////////////////////////////////////////////////////////////////////////////
   // handshake terms
   assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
   assign rd_valid = (cnt_q != '0);
   assign push     = wr_valid && wr_ready;
   assign pop      = rd_valid && rd_ready;
   assign rd_data  = mem[rptr_q];
   assign level    = cnt_q;

   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr_q] <= wr_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + AW'(1);
         end
         if (pop) begin
            rptr_q <= rptr_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== rx_rate_match_elastic_buffer.sv ====
// receive elastic buffer with rate-match deletion/insertion and fault fill
//
// Notes on behaviour
// - The buffer holds 32 words of 64 data bits plus 8 control bits.
// - When no word can be read, local fault codes go out instead of data.
// - The fill level is steered toward half the depth.
// - Above half full, incoming idle rate-match words outside a frame are deleted.
// - Below half full, an idle rate-match head word is repeated on output unless a frame is open there.
// - Words that arrive while the buffer is full are dropped and flagged with a pulse.
// - All receive outputs are registered on the single core clock.
// - Latency through the block grows with the fill level.
`timescale 1ns/100ps
module rx_rate_match_elastic_buffer
   import rrmeb_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        in_valid,
   input  wire logic [63:0] in_data,
   input  wire logic [7:0]  in_ctrl,
   output      logic [63:0] xgmii_rxd,
   output      logic [7:0]  xgmii_rxc,
   output      logic [5:0]  fill_level,
   output      logic        delete_pulse,
   output      logic        insert_pulse,
   output      logic        drop_pulse,
   output      logic        fault_active,
   output      logic        cc_overflow
);
   // reset copy, fifo handshake and registered outputs
   logic                    rst_meta_q;
   logic                    rst_n_q;
   logic                    in_frame_q;
   logic                    wr_valid;
   logic                    wr_ready;
   logic                    rd_valid;
   logic                    rd_ready;
   logic [RRMEB_WORD_W-1:0] rd_word;
   logic [5:0]              level;
   logic                    in_is_rms;
   logic                    del_now;
   logic                    ins_now;
   logic                    head_is_rms;
   logic                    out_frame_q;
   logic [6:0]              cc_q;
   logic [63:0]             rxd_q;
   logic [7:0]              rxc_q;
   logic [5:0]              lvl_q;
   logic                    del_q;
   logic                    ins_q;
   logic                    drop_q;
   logic                    flt_q;
   logic                    ovf_q;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   // nrst may drop at any time, but the rest of the block only leaves reset on an edge
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write side: frame tracking and deletion
   // deletion acts before the fifo, so a deleted word never takes a slot;
   // inside a frame nothing is deleted, whatever the level
   assign in_is_rms = rrmeb_is_rms(in_data, in_ctrl);
   assign del_now   = in_valid && in_is_rms && !in_frame_q && (level > RRMEB_HALF);
   assign wr_valid  = in_valid && !del_now;

   // frame state from start and terminate characters
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         in_frame_q <= 1'b0;
      end else if (in_valid) begin
         if (rrmeb_has_term(in_data, in_ctrl)) begin
            in_frame_q <= 1'b0;
         end else if (rrmeb_has_start(in_data, in_ctrl)) begin
            in_frame_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage, 32 words of 72 bits
   // with reads every cycle the level only climbs while the output inserts
   rrmeb_fifo #(
      .WIDTH (RRMEB_WORD_W),
      .DEPTH (RRMEB_DEPTH),
      .AW    (RRMEB_AW)
   ) u_fifo (
      .clk      (clk_sys),
      .rst_n    (rst_n_q),
      .wr_valid (wr_valid),
      .wr_data  ({in_ctrl, in_data}),
      .wr_ready (wr_ready),
      .rd_valid (rd_valid),
      .rd_data  (rd_word),
      .rd_ready (rd_ready),
      .level    (level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read side: insertion holds an idle head word back for as long as the level stays below half
   // the held word is repeated without being consumed, so writes catch up
   // toward half full; an open frame on the output blocks it
   assign head_is_rms = rrmeb_is_rms(rd_word[63:0], rd_word[71:64]);
   assign ins_now     = rd_valid && (level < RRMEB_HALF) && head_is_rms
                        && !out_frame_q;
   assign rd_ready    = rd_valid && !ins_now;

   // frame state of the words already handed on
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         out_frame_q <= 1'b0;
      end else if (rd_ready) begin
         if (rrmeb_has_term(rd_word[63:0], rd_word[71:64])) begin
            out_frame_q <= 1'b0;
         end else if (rrmeb_has_start(rd_word[63:0], rd_word[71:64])) begin
            out_frame_q <= 1'b1;
         end
      end
   end

   // output word selection, registered
   // an empty buffer shows local fault rather than a stale word
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rxd_q <= RRMEB_RST_D;
         rxc_q <= RRMEB_RST_C;
         flt_q <= 1'b1;
      end else if (rd_ready) begin
         rxd_q <= rd_word[63:0];
         rxc_q <= rd_word[71:64];
         flt_q <= 1'b0;
      end else if (ins_now) begin
         rxd_q <= RRMEB_IDLE_D;
         rxc_q <= RRMEB_IDLE_C;
         flt_q <= 1'b0;
      end else begin
         rxd_q <= RRMEB_LFAULT_D;
         rxc_q <= RRMEB_LFAULT_C;
         flt_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event pulses and level
   // one-cycle pulse for every idle word deleted at the input
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         del_q <= 1'b0;
      end else begin
         del_q <= del_now;
      end
   end

   // one-cycle pulse for every idle word inserted at the output
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ins_q <= 1'b0;
      end else begin
         ins_q <= ins_now;
      end
   end

   // one-cycle pulse for every word lost to a full buffer
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         drop_q <= 1'b0;
      end else begin
         drop_q <= wr_valid && !wr_ready;
      end
   end

   // fill level one cycle late; the output delay grows with it
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lvl_q <= '0;
      end else begin
         lvl_q <= level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // idle words held above half full, saturating at the 64 allowance
   // the count restarts whenever the level falls back to half
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cc_q <= '0;
      end else if (level <= RRMEB_HALF) begin
         cc_q <= '0;
      end else if (in_valid && in_is_rms && wr_ready && !del_now
                   && cc_q != RRMEB_CC_LIMIT) begin
         cc_q <= cc_q + 7'h01;
      end
   end

   // overflow flag: a word was just dropped, or the allowance is used up
   // it is a level, not sticky, so it falls once the buffer drains
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= (wr_valid && !wr_ready) || (cc_q == RRMEB_CC_LIMIT);
      end
   end

   // every output straight from a register
   assign xgmii_rxd    = rxd_q;
   assign xgmii_rxc    = rxc_q;
   assign fill_level   = lvl_q;
   assign delete_pulse = del_q;
   assign insert_pulse = ins_q;
   assign drop_pulse   = drop_q;
   assign fault_active = flt_q;
   assign cc_overflow  = ovf_q;
endmodule

// ==== rrmeb_checker.sv ====
// checker of the elastic buffer port rules
`timescale 1ns/100ps
module rrmeb_checker
   import rrmeb_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        in_valid,
   input wire logic [63:0] in_data,
   input wire logic [7:0]  in_ctrl,
   input wire logic [63:0] xgmii_rxd,
   input wire logic [7:0]  xgmii_rxc,
   input wire logic [5:0]  fill_level,
   input wire logic        delete_pulse,
   input wire logic        insert_pulse,
   input wire logic        drop_pulse,
   input wire logic        fault_active,
   input wire logic        cc_overflow
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // local fault word on the output
   sequence s_fault_word;
      xgmii_rxd == RRMEB_LFAULT_D && xgmii_rxc == RRMEB_LFAULT_C;
   endsequence
   // drop followed by overflow flag
   sequence s_drop_flag;
      drop_pulse ##[0:2] cc_overflow;
   endsequence
   AST_FAULT: assert property (fault_active |-> s_fault_word)
      else $error("fault word not shown");
   AST_RESET: assert property ($rose(nrst) |-> fault_active && fill_level == 6'h00)
      else $error("bad state after reset");
   AST_FILL: assert property (fill_level <= 6'h20)
      else $error("fill above depth");
   AST_DEL: assert property (delete_pulse |-> $past(in_valid) &&
      $past(in_ctrl) == RRMEB_IDLE_C && $past(in_data) == RRMEB_IDLE_D)
      else $error("non idle word deleted");
   AST_DLVL: assert property (delete_pulse |-> fill_level >= 6'h0F)
      else $error("delete while low");
   AST_ILVL: assert property (insert_pulse |-> fill_level <= 6'h11)
      else $error("insert while high");
   AST_DROP: assert property (drop_pulse |-> $past(in_valid))
      else $error("drop without input");
   AST_OVF: assert property (drop_pulse |-> s_drop_flag)
      else $error("drop without overflow flag");
endmodule

// ==== rrmeb_mac_model.sv ====
// mac-side receive model counting frame starts
`timescale 1ns/100ps
module rrmeb_mac_model
   import rrmeb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [63:0] rxd,
   input  wire logic [7:0]  rxc,
   output      logic [7:0]  n_start
);
   // start characters in lane 0 or 4, sampled on the core clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n_start <= 8'h00;
      end else if ((rxc[0] && rxd[7:0] == RRMEB_CH_START) ||
                   (rxc[4] && rxd[39:32] == RRMEB_CH_START)) begin
         n_start <= n_start + 8'h01;
      end
   end
endmodule

// ==== rx_rate_match_elastic_buffer_tb.sv ====
// testbench of the receive rate-match elastic buffer
`timescale 1ns/100ps
module rx_rate_match_elastic_buffer_tb import rrmeb_pkg::*;;
   logic        clk_sys, nrst, in_valid;
   logic [63:0] in_data, xgmii_rxd;
   logic [7:0]  in_ctrl, xgmii_rxc, n_start, n_ins;
   logic [5:0]  fill_level;
   logic        delete_pulse, insert_pulse, drop_pulse, fault_active, cc_overflow;
   int          n_errors, n_compared, k;
   // rows: start flag, control, data; the word must come out unchanged
   logic [72:0] rows [5] = '{{1'h1, 8'h01, 64'hD5555555555555FB},
      {1'h0, 8'h00, 64'h0123456789ABCDEF}, {1'h0, 8'hFF, 64'h07070707070707FD},
      {1'h1, 8'h1F, 64'h555555FB07070707}, {1'h0, 8'hFE, 64'h070707070707FD33}};
   rx_rate_match_elastic_buffer dut (
      .clk_sys      (clk_sys),
      .nrst         (nrst),
      .in_valid     (in_valid),
      .in_data      (in_data),
      .in_ctrl      (in_ctrl),
      .xgmii_rxd    (xgmii_rxd),
      .xgmii_rxc    (xgmii_rxc),
      .fill_level   (fill_level),
      .delete_pulse (delete_pulse),
      .insert_pulse (insert_pulse),
      .drop_pulse   (drop_pulse),
      .fault_active (fault_active),
      .cc_overflow  (cc_overflow)
   );
   rrmeb_mac_model mac (.clk(clk_sys), .rst_n(nrst), .rxd(xgmii_rxd), .rxc(xgmii_rxc),
      .n_start(n_start));
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // count inserted idle words
   always @(posedge clk_sys) n_ins <= nrst ? n_ins + 8'(insert_pulse) : 8'h00;
   // watchdog
   initial begin
      #20000;
      n_errors++;
      final_report();
   end
   initial begin
      nrst = 1'b0;
      in_valid = 1'b0;
      in_data = 64'h0;
      in_ctrl = 8'h00;
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check(fault_active, 1'b1);
      // single words pass unchanged, then the empty buffer shows fault
      foreach (rows[i]) begin
         {in_ctrl, in_data} = rows[i][71:0];
         in_valid = 1'b1;
         @(posedge clk_sys);
         #1 in_valid = 1'b0;
         k = 0;
         while (fault_active !== 1'b0 && k < 10) begin
            @(posedge clk_sys);
            #1 k++;
         end
         check({xgmii_rxc, xgmii_rxd}, rows[i][71:0]);
         @(posedge clk_sys);
         #1 check({xgmii_rxc, xgmii_rxd}, {RRMEB_LFAULT_C, RRMEB_LFAULT_D});
      end
      check(n_start, 8'h02);
      // idle stream: buffer steered to half full by insertion
      {in_ctrl, in_data} = {RRMEB_IDLE_C, RRMEB_IDLE_D};
      in_valid = 1'b1;
      repeat (40) @(posedge clk_sys);
      #1 check(fill_level, RRMEB_HALF);
      check(n_ins > 8'h00, 1'b1);
      check({xgmii_rxc, xgmii_rxd}, {RRMEB_IDLE_C, RRMEB_IDLE_D});
      check(drop_pulse, 1'b0);
      check(delete_pulse, 1'b0);
      check(cc_overflow, 1'b0);
      in_valid = 1'b0;
      // reset in mid-run acts at once
      nrst = 1'b0;
      #1 check(fault_active, 1'b1);
      check(fill_level, 6'h00);
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 check({xgmii_rxc, xgmii_rxd}, {RRMEB_LFAULT_C, RRMEB_LFAULT_D});
      check(fill_level, 6'h00);
      // idle words inside an open frame pass once each, nothing is inserted
      k = int'(n_ins);
      {in_ctrl, in_data} = rows[0][71:0];
      in_valid = 1'b1;
      @(posedge clk_sys);
      #1 {in_ctrl, in_data} = {RRMEB_IDLE_C, RRMEB_IDLE_D};
      repeat (10) @(posedge clk_sys);
      #1 check(n_ins, k[7:0]);
      check(fill_level, 6'h01);
      check({xgmii_rxc, xgmii_rxd}, {RRMEB_IDLE_C, RRMEB_IDLE_D});
      in_valid = 1'b0;
      final_report();
   end
endmodule
bind rx_rate_match_elastic_buffer rrmeb_checker chk (
   .clk_sys      (clk_sys),
   .nrst         (nrst),
   .in_valid     (in_valid),
   .in_data      (in_data),
   .in_ctrl      (in_ctrl),
   .xgmii_rxd    (xgmii_rxd),
   .xgmii_rxc    (xgmii_rxc),
   .fill_level   (fill_level),
   .delete_pulse (delete_pulse),
   .insert_pulse (insert_pulse),
   .drop_pulse   (drop_pulse),
   .fault_active (fault_active),
   .cc_overflow  (cc_overflow)
);
